// ===== hw/romseq_regs.vh
/*
 * Constants for the operating mode sequencer: mode codes, field
 * position of the mode field and the sequence timing figures.
 * Assumes the includer uses a 100 MHz core clock.
 */
`ifndef ROMSEQ_REGS_VH
`define ROMSEQ_REGS_VH

// Mode field position inside the main mode control byte
`define ROMSEQ_MODE_MSB 7
`define ROMSEQ_MODE_LSB 5
`define ROMSEQ_CTRL_RESET 8'h20

// Mode codes
`define ROMSEQ_MODE_SLEEP 3'h0
`define ROMSEQ_MODE_STANDBY 3'h1
`define ROMSEQ_MODE_SYNTH 3'h2
`define ROMSEQ_MODE_RX 3'h3
`define ROMSEQ_MODE_TX 3'h4

// Clock rate and timing figures
`define ROMSEQ_CLK_MHZ 100
`define ROMSEQ_XTAL_MAX_US 5000
`define ROMSEQ_LOCK_MAX_US 500
`define ROMSEQ_SLEEP_MAX_US 1000
`define ROMSEQ_WAKE_MAX_US 6000
// Edges from the sampled mode to a stage output, on top of the timer count
`define ROMSEQ_SEQ_LATENCY 2
// Counts cut by that latency, and by one more for the lock and sleep limits, so each limit holds in whole cycles
`define ROMSEQ_XTAL_CYC (`ROMSEQ_XTAL_MAX_US * `ROMSEQ_CLK_MHZ - `ROMSEQ_SEQ_LATENCY)
`define ROMSEQ_LOCK_CYC (`ROMSEQ_LOCK_MAX_US * `ROMSEQ_CLK_MHZ - `ROMSEQ_SEQ_LATENCY - 1)
`define ROMSEQ_SLEEP_CYC (`ROMSEQ_SLEEP_MAX_US * `ROMSEQ_CLK_MHZ - `ROMSEQ_SEQ_LATENCY - 1)

`endif

// ===== hw/romseq_timer.v
/*
 * Down counter used for each stage delay of the sequencer.
 * Assumes load is a single-cycle pulse on core_clk.
 */
`timescale 1ns/10ps
`default_nettype none
module romseq_timer #(
	parameter WIDTH = 20
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Control
	input wire load,
	input wire [WIDTH-1:0] load_value,
	// Status
	output wire done
);
	reg [WIDTH-1:0] count_reg;

	// Load wins over counting; stops at zero
	always @(posedge core_clk or posedge reset) begin
		if (reset)
			count_reg <= {WIDTH{1'b0}};
		else if (load)
			count_reg <= load_value;
		else if (count_reg != {WIDTH{1'b0}})
			count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
	end

	assign done = (count_reg == {WIDTH{1'b0}}) && !load;
endmodule
`default_nettype wire

// ===== hw/romseq_sequencer.v
/*
 * Operating mode sequencer: follows the mode field from the host,
 * brings the crystal oscillator and PLL up in stages, reports lock,
 * and gates the buffered reference clock output in sleep.
 * Assumes the mode field is held in a register outside and arrives
 * synchronous to core_clk.
 */
// Behaviour
// - Mode 000 sleep, 001 standby, 010 synth, 011 receive, 100 transmit.
// - Crystal oscillator usable within 5 ms after sleep to standby.
// - PLL locks in under 0.5 ms after standby to synthesizer.
// - Lock output pin shows whether PLL is locked now.
// - Whole wake-up from sleep to rx or tx under 6 ms.
// - Buffered reference clock output held inactive during sleep.
// - Shutdown to sleep completes in under 1 ms.
`timescale 1ns/10ps
`include "romseq_regs.vh"
`default_nettype none
module romseq_sequencer #(
	parameter XTAL_CYCLES = `ROMSEQ_XTAL_CYC,
	parameter LOCK_CYCLES = `ROMSEQ_LOCK_CYC,
	parameter SLEEP_CYCLES = `ROMSEQ_SLEEP_CYC
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Mode field of main_mode_control
	input wire [2:0] mode_field,
	// Reference clock to buffer out
	input wire ref_clk_in,
	// Analog enables
	output reg xtal_osc_enable,
	output reg pll_enable,
	output reg rx_enable,
	output reg tx_enable,
	// Status
	output reg xtal_ready,
	output reg pll_lock,
	output reg sleep_reached,
	output wire [2:0] current_mode,
	// Buffered clock output
	output wire clk_out
);
	localparam TW = 20;
	// Counts held as 32-bit words, then cut to the timer width on purpose
	localparam [31:0] XTAL_WORD = XTAL_CYCLES;
	localparam [31:0] LOCK_WORD = LOCK_CYCLES;
	localparam [31:0] SLEEP_WORD = SLEEP_CYCLES;
	localparam [TW-1:0] XTAL_LOAD = XTAL_WORD[TW-1:0];
	localparam [TW-1:0] LOCK_LOAD = LOCK_WORD[TW-1:0];
	localparam [TW-1:0] SLEEP_LOAD = SLEEP_WORD[TW-1:0];

	// Sequencer states
	localparam [2:0] ST_SLEEP = 3'h0;
	localparam [2:0] ST_XTAL_START = 3'h1;
	localparam [2:0] ST_STANDBY = 3'h2;
	localparam [2:0] ST_PLL_START = 3'h3;
	localparam [2:0] ST_SYNTH = 3'h4;
	localparam [2:0] ST_ACTIVE = 3'h5;
	localparam [2:0] ST_SHUTDOWN = 3'h6;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [2:0] mode_reg;
	reg [2:0] mode_next;
	reg timer_load;
	reg [TW-1:0] timer_value;
	wire timer_done;
	reg [2:0] current_mode_reg;

	// Code is one of the five documented modes
	function valid_mode;
		input [2:0] code;
		begin
			valid_mode = (code <= `ROMSEQ_MODE_TX);
		end
	endfunction

	// Mode needs the PLL running
	function needs_pll;
		input [2:0] code;
		begin
			needs_pll = (code >= `ROMSEQ_MODE_SYNTH) && valid_mode(code);
		end
	endfunction

	// State in which the PLL has settled
	function locked_state;
		input [2:0] st;
		begin
			locked_state = (st == ST_SYNTH) || (st == ST_ACTIVE);
		end
	endfunction

	// Mode a state reports; the active state reports the latched mode code, so a switch between rx and tx shows at once
	function [2:0] reported_mode;
		input [2:0] st;
		input [2:0] code;
		begin
			case (st)
				ST_ACTIVE: reported_mode = code;
				ST_SYNTH: reported_mode = `ROMSEQ_MODE_SYNTH;
				ST_STANDBY, ST_PLL_START: reported_mode = `ROMSEQ_MODE_STANDBY;
				default: reported_mode = `ROMSEQ_MODE_SLEEP;
			endcase
		end
	endfunction

	// Stage delay timer
	romseq_timer #(
		.WIDTH(TW)
	) u_timer (
		.core_clk(core_clk),
		.reset(reset),
		.load(timer_load),
		.load_value(timer_value),
		.done(timer_done)
	);

	// Latched mode; reserved codes keep the previous one
	always @* begin
		mode_next = valid_mode(mode_field) ? mode_field : mode_reg;
	end

	// Stage sequencing
	always @* begin
		state_next = state_reg;
		timer_load = 1'b0;
		timer_value = {TW{1'b0}};
		case (state_reg)
			ST_SLEEP: begin
				if (mode_reg != `ROMSEQ_MODE_SLEEP) begin
					state_next = ST_XTAL_START;
					timer_load = 1'b1;
					timer_value = XTAL_LOAD;
				end
			end
			ST_XTAL_START: begin
				if (mode_reg == `ROMSEQ_MODE_SLEEP) begin
					state_next = ST_SHUTDOWN;
					timer_load = 1'b1;
					timer_value = SLEEP_LOAD;
				end else if (timer_done)
					state_next = ST_STANDBY;
			end
			ST_STANDBY: begin
				if (mode_reg == `ROMSEQ_MODE_SLEEP) begin
					state_next = ST_SHUTDOWN;
					timer_load = 1'b1;
					timer_value = SLEEP_LOAD;
				end else if (needs_pll(mode_reg)) begin
					state_next = ST_PLL_START;
					timer_load = 1'b1;
					timer_value = LOCK_LOAD;
				end
			end
			ST_PLL_START: begin
				if (mode_reg == `ROMSEQ_MODE_SLEEP) begin
					state_next = ST_SHUTDOWN;
					timer_load = 1'b1;
					timer_value = SLEEP_LOAD;
				end else if (!needs_pll(mode_reg))
					state_next = ST_STANDBY;
				else if (timer_done)
					state_next = ST_SYNTH;
			end
			ST_SYNTH, ST_ACTIVE: begin
				// Rx or tx only entered from a locked synthesizer
				if (mode_reg == `ROMSEQ_MODE_SLEEP) begin
					state_next = ST_SHUTDOWN;
					timer_load = 1'b1;
					timer_value = SLEEP_LOAD;
				end else if (!needs_pll(mode_reg))
					state_next = ST_STANDBY;
				else if (mode_reg == `ROMSEQ_MODE_SYNTH)
					state_next = ST_SYNTH;
				else
					state_next = ST_ACTIVE;
			end
			ST_SHUTDOWN: begin
				// Enables already off; wait out the settle time
				if (timer_done)
					state_next = ST_SLEEP;
			end
			default: state_next = ST_SLEEP;
		endcase
	end

	// State, mode and output flip-flops
	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_SLEEP;
			mode_reg <= `ROMSEQ_MODE_SLEEP;
			xtal_osc_enable <= 1'b0;
			pll_enable <= 1'b0;
			rx_enable <= 1'b0;
			tx_enable <= 1'b0;
			xtal_ready <= 1'b0;
			pll_lock <= 1'b0;
			sleep_reached <= 1'b1;
			current_mode_reg <= `ROMSEQ_MODE_SLEEP;
		end else begin
			state_reg <= state_next;
			mode_reg <= mode_next;
			// Oscillator runs everywhere except sleep and shutdown
			xtal_osc_enable <= (state_next != ST_SLEEP) && (state_next != ST_SHUTDOWN);
			pll_enable <= (state_next == ST_PLL_START) || locked_state(state_next);
			rx_enable <= (state_next == ST_ACTIVE) && (mode_reg == `ROMSEQ_MODE_RX);
			tx_enable <= (state_next == ST_ACTIVE) && (mode_reg == `ROMSEQ_MODE_TX);
			xtal_ready <= (state_next == ST_STANDBY) || (state_next == ST_PLL_START) ||
				locked_state(state_next);
			pll_lock <= locked_state(state_next);
			sleep_reached <= (state_next == ST_SLEEP);
			// Same inputs as the rx and tx enables, so the reported mode never lags them
			current_mode_reg <= reported_mode(state_next, mode_reg);
		end
	end

	// Reported mode follows the state actually reached
	assign current_mode = current_mode_reg;

	// Clock out only while the crystal is usable; low in sleep
	assign clk_out = ref_clk_in & xtal_ready;
endmodule
`default_nettype wire

// ===== tb/romseq_seq_asserts.sv
/* Checker for the mode sequencer.
   Assumes binding to romseq_sequencer with small stage counts. */
`timescale 1ns/10ps
`default_nettype none
module romseq_seq_asserts #(
	parameter int XTAL_CYCLES = 20,
	parameter int LOCK_CYCLES = 10,
	parameter int SLEEP_CYCLES = 10
) (
	// Clock and reset
	input wire core_clk,
	input wire reset,
	// Inputs
	input wire [2:0] mode_field,
	input wire ref_clk_in,
	// Outputs
	input wire xtal_osc_enable,
	input wire pll_enable,
	input wire rx_enable,
	input wire tx_enable,
	input wire xtal_ready,
	input wire pll_lock,
	input wire sleep_reached,
	input wire [2:0] current_mode,
	input wire clk_out
);
	localparam int XW = XTAL_CYCLES + 4;
	localparam int LW = LOCK_CYCLES + 4;
	localparam int SW = SLEEP_CYCLES + 4;
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// Stage timing, gating and lock relations
	a_clk_gate: assert property (clk_out == (ref_clk_in & xtal_ready))
		else $error("clock output gating wrong");
	a_sleep_quiet: assert property (sleep_reached |-> !clk_out && !pll_lock)
		else $error("activity in sleep");
	a_osc_wake: assert property ($rose(xtal_osc_enable) |-> ##[1:XW] xtal_ready)
		else $error("crystal late");
	a_pll_lock: assert property ($rose(pll_enable) |-> ##[1:LW] pll_lock)
		else $error("lock late");
	a_lock_pin: assert property (pll_lock |-> pll_enable && xtal_ready)
		else $error("lock without pll");
	a_sleep_time: assert property ($fell(xtal_osc_enable) |-> ##[1:SW] sleep_reached)
		else $error("sleep late");
	a_tx_locked: assert property (tx_enable |-> pll_lock && current_mode == 3'h4)
		else $error("tx without lock");
	a_rx_locked: assert property (rx_enable |-> pll_lock && current_mode == 3'h3)
		else $error("rx without lock");
endmodule
bind romseq_sequencer romseq_seq_asserts #(.XTAL_CYCLES(XTAL_CYCLES),
	.LOCK_CYCLES(LOCK_CYCLES), .SLEEP_CYCLES(SLEEP_CYCLES)) u_romseq_seq_asserts (
	.core_clk(core_clk), .reset(reset), .mode_field(mode_field), .ref_clk_in(ref_clk_in),
	.xtal_osc_enable(xtal_osc_enable), .pll_enable(pll_enable), .rx_enable(rx_enable),
	.tx_enable(tx_enable), .xtal_ready(xtal_ready), .pll_lock(pll_lock),
	.sleep_reached(sleep_reached), .current_mode(current_mode), .clk_out(clk_out));
`default_nettype wire

// ===== tb/romseq_host_model.sv
/* Host model that writes the mode field.
   Assumes it is clocked by core_clk and sees the lock pin. */
`timescale 1ns/10ps
`default_nettype none
module romseq_host_model (
	// Clock and lock pin
	input wire core_clk,
	input wire pll_lock,
	// Mode field
	output logic [2:0] mode_field
);
	initial mode_field = 3'h0;
	// Serial port lines rest at their low-current levels; no transfer is modelled
	logic config_port_select_n = 1'b0;
	logic fifo_port_select_n = 1'b1;
	logic serial_in = 1'b0;
	logic serial_clk = 1'b0;
	wire [3:0] quiet_lines = {config_port_select_n, fifo_port_select_n, serial_in, serial_clk};
	// Write a code just after an edge
	task automatic set_mode(input logic [2:0] code);
		@(posedge core_clk);
		#1 mode_field = code;
	endtask
	// Step up, then pick the active mode once lock shows
	task automatic wake_to(input logic [2:0] active);
		set_mode(3'h1);
		set_mode(3'h2);
		repeat (200) if (pll_lock !== 1'b1) begin
			@(posedge core_clk);
			#1;
		end
		set_mode(active);
	endtask
endmodule
`default_nettype wire

// ===== tb/test_radio_operating_mode_sequencer.sv
/* Self-checking bench for the mode sequencer.
   Assumes stage counts cut to 20, 10 and 10 cycles. */
`timescale 1ns/10ps
`default_nettype none
module test_radio_operating_mode_sequencer;
	localparam int XC = 20;
	localparam int LC = 10;
	localparam int SC = 10;
	logic core_clk = 0;
	logic reset = 1;
	logic ref_clk_in = 0;
	wire [2:0] mode_field, current_mode;
	wire xtal_osc_enable, pll_enable, rx_enable, tx_enable;
	wire xtal_ready, pll_lock, sleep_reached, clk_out;
	wire [2:0] st = {sleep_reached, pll_lock, xtal_ready};
	int fail_count = 0;
	int compares = 0;
	int t, n;
	romseq_sequencer #(.XTAL_CYCLES(XC), .LOCK_CYCLES(LC), .SLEEP_CYCLES(SC)) u_romseq_sequencer (
		.core_clk(core_clk), .reset(reset), .mode_field(mode_field), .ref_clk_in(ref_clk_in),
		.xtal_osc_enable(xtal_osc_enable), .pll_enable(pll_enable), .rx_enable(rx_enable),
		.tx_enable(tx_enable), .xtal_ready(xtal_ready), .pll_lock(pll_lock),
		.sleep_reached(sleep_reached), .current_mode(current_mode), .clk_out(clk_out));
	romseq_host_model u_romseq_host_model (
		.core_clk(core_clk), .pll_lock(pll_lock), .mode_field(mode_field));
	// Clocks
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) ref_clk_in <= #1 ~ref_clk_in;
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Count cycles until a status bit is high
	task automatic wait_on(input int sel, output int c);
		c = 0;
		while (c < 200 && st[sel] !== 1'b1) begin
			@(posedge core_clk);
			#1 c++;
		end
	endtask
	task automatic set(input logic [2:0] code, input int k);
		u_romseq_host_model.set_mode(code);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic finish_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog
	initial begin
		#100000;
		fail_count++;
		finish_test();
	end
	// Start-up reset leaves the block asleep with the clock output low
	task automatic test_reset();
		repeat (20) @(posedge core_clk);
		#1 reset = 0;
		chk("reset sleep", 4'h8, {sleep_reached, pll_lock, xtal_ready, xtal_osc_enable});
		chk("reset clk", 4'h0, {3'h0, clk_out});
		repeat (2) @(posedge core_clk);
		#1 chk("still asleep", 4'h8, {sleep_reached, current_mode});
		$display("reset test done");
	endtask
	// Wake from sleep through standby and synthesizer into transmit
	task automatic test_wake();
		set(3'h1, 0);
		wait_on(0, t);
		chk("xtal time", 4'h1, {3'h0, t >= XC - 2 && t <= XC + 3});
		chk("standby", 4'h1, {1'b0, current_mode});
		chk("standby en", 4'h8, {xtal_osc_enable, pll_enable, rx_enable, tx_enable});
		#2 chk("standby clk", {3'h0, ref_clk_in}, {3'h0, clk_out});
		set(3'h2, 0);
		wait_on(1, n);
		chk("lock time", 4'h1, {3'h0, n <= LC + 3});
		chk("lock pin", 4'h1, {3'h0, pll_lock});
		chk("synth", 4'h2, {1'b0, current_mode});
		chk("synth en", 4'hc, {xtal_osc_enable, pll_enable, rx_enable, tx_enable});
		set(3'h4, 3);
		chk("tx", 4'hc, {tx_enable, current_mode});
		chk("wake time", 4'h1, {3'h0, t + n + 6 <= XC + LC + 12});
		$display("wake test done");
	endtask
	// Reserved codes keep transmit; then a direct switch to receive
	task automatic test_reserved();
		for (int c = 5; c < 8; c++) begin
			set(c[2:0], 4);
			chk("reserved", 4'hc, {tx_enable, current_mode});
		end
		set(3'h3, 3);
		chk("rx", 4'hb, {rx_enable, current_mode});
		chk("tx off", 4'h0, {3'h0, tx_enable});
		$display("reserved test done");
	endtask
	// Sleep from receive, then a full wake back into receive
	task automatic test_sleep();
		set(3'h0, 0);
		wait_on(2, t);
		chk("sleep time", 4'h1, {3'h0, t <= SC + 4});
		chk("sleep state", 4'h0, {clk_out, current_mode});
		chk("sleep en", 4'h0, {xtal_osc_enable, pll_enable, rx_enable, tx_enable});
		chk("host quiet", 4'h4, u_romseq_host_model.quiet_lines);
		u_romseq_host_model.wake_to(3'h3);
		repeat (3) @(posedge core_clk);
		#1 chk("rewake rx", 4'hb, {rx_enable, current_mode});
		$display("sleep test done");
	endtask
	// Reset in mid-run drops receive at once and the block stays asleep after it
	task automatic test_mid_reset();
		reset = 1;
		u_romseq_host_model.set_mode(3'h0);
		chk("reset drop", 4'h8, {sleep_reached, rx_enable, pll_lock, xtal_ready});
		@(posedge core_clk);
		#1 reset = 0;
		repeat (2) @(posedge core_clk);
		#1 chk("reset idle", 4'h8, {sleep_reached, current_mode});
		chk("mid clk", 4'h0, {xtal_osc_enable, pll_enable, rx_enable, clk_out});
		$display("mid reset test done");
	endtask
	// Scenarios
	initial begin
		test_reset();
		test_wake();
		test_reserved();
		test_sleep();
		test_mid_reset();
		finish_test();
	end
endmodule
`default_nettype wire
